//--- ome_exec.sv
`timescale 1ns/1ps
// Operate and jump instruction executor with an AXI4-Lite register slave
`include "ome_regs.svh"
module ome_exec #(
  parameter int ADDR_W = `OME_AXI_AW,
  parameter int DATA_W = 32
) (
  input  logic                aclk,
  input  logic                aresetn,
  input  logic [ADDR_W-1:0]   awaddr,
  input  logic                awvalid,
  output logic                awready,
  input  logic [DATA_W-1:0]   wdata,
  input  logic [DATA_W/8-1:0] wstrb,
  input  logic                wvalid,
  output logic                wready,
  output logic [1:0]          bresp,
  output logic                bvalid,
  input  logic                bready,
  input  logic [ADDR_W-1:0]   araddr,
  input  logic                arvalid,
  output logic                arready,
  output logic [DATA_W-1:0]   rdata,
  output logic [1:0]          rresp,
  output logic                rvalid,
  input  logic                rready,
  output ome_pkg::ome_memwr_s mem_wr,
  output logic                int_inhibit,
  output logic                running
);
  import ome_pkg::*;

  localparam int DW = DATA_W;

  ome_state_e      state_reg;
  ome_state_e      state_next;
  ome_word_t       instr_reg;
  ome_word_t       instr_next;
  ome_word_t       acc_reg;
  ome_word_t       acc_next;
  logic            link_reg;
  logic            link_next;
  ome_addr_t       pc_reg;
  ome_addr_t       pc_next;
  ome_word_t       sw_reg;
  ome_word_t       sw_next;
  logic            run_reg;
  logic            run_next;
  logic            bank_reg;
  logic            bank_next;
  logic            user_reg;
  logic            user_next;
  logic            prot_reg;
  logic            prot_next;
  logic            unsup_reg;
  logic            unsup_next;
  logic            inhib_reg;
  logic            inhib_next;
  ome_memwr_s      memwr_reg;
  ome_memwr_s      memwr_next;
  ome_word_t       deposit;
  ome_opr_s        opr_res;

  logic            awready_reg;
  logic            awready_next;
  logic            bvalid_reg;
  logic            bvalid_next;
  logic [1:0]      bresp_reg;
  logic [1:0]      bresp_next;
  logic            arready_reg;
  logic            arready_next;
  logic            rvalid_reg;
  logic            rvalid_next;
  logic [1:0]      rresp_reg;
  logic [1:0]      rresp_next;
  logic [DW-1:0]   rdata_reg;
  logic [DW-1:0]   rdata_next;
  logic [DW-1:0]   ctrl_rd;
  logic [DW-1:0]   stat_rd;

  // Byte-lane merge of a write into the old register value
  function automatic logic [DW-1:0] merge(input logic [DW-1:0]   old_v,
                                          input logic [DW-1:0]   new_v,
                                          input logic [DW/8-1:0] strb);
    logic [DW-1:0] m;
    m = old_v;
    for (int i = 0; i < DW / 8; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Instruction decode
  wire [3:0]      opcode   = instr_reg[`OME_OP_HI:`OME_OP_LO];
  wire            is_opr   = opcode == `OME_OP_OPR;   // see RL1
  wire            is_ujump = opcode == `OME_OP_UJUMP;
  wire            is_call  = opcode == `OME_OP_CALL;
  wire ome_addr_t y_addr   = instr_reg[`OME_AW-1:0];
  wire            in_exec  = state_reg == ST_EXEC;
  wire            in_call  = state_reg == ST_CALL;
  wire            busy     = state_reg != ST_IDLE;
  wire            opr_exec = in_exec & is_opr;
  wire            jump_now = in_exec & is_ujump;

  // All microactions of the word are evaluated in one cycle, chained in RL9 order
  ome_opr_unit u_opr (                                // see RL3
    .word     (instr_reg),
    .acc_in   (acc_reg),
    .link_in  (link_reg),
    .switches (sw_reg),
    .result   (opr_res)
  );

  // Write address decode
  wire hit_ctrl  = awaddr == ADDR_W'(`OME_A_CTRL);
  wire hit_stat  = awaddr == ADDR_W'(`OME_A_STAT);
  wire hit_instr = awaddr == ADDR_W'(`OME_A_INSTR);
  wire hit_acc   = awaddr == ADDR_W'(`OME_A_ACC);
  wire hit_link  = awaddr == ADDR_W'(`OME_A_LINK);
  wire hit_pc    = awaddr == ADDR_W'(`OME_A_PC);
  wire hit_sw    = awaddr == ADDR_W'(`OME_A_SW);
  wire hit_core  = hit_instr | hit_acc | hit_link | hit_pc;
  wire wr_take   = awready_reg & awvalid & wvalid;
  wire wr_ok     = hit_ctrl | hit_stat | hit_sw |
                   (hit_core & ~busy & ~(hit_instr & ~run_reg));
  wire we_ctrl   = wr_take & hit_ctrl;
  wire we_sw     = wr_take & hit_sw;
  wire we_acc    = wr_take & hit_acc & ~busy;
  wire we_link   = wr_take & hit_link & ~busy;
  wire we_pc     = wr_take & hit_pc & ~busy;
  wire start     = wr_take & hit_instr & ~busy & run_reg;

  wire [DW-1:0] wm_ctrl  = merge(ctrl_rd, wdata, wstrb);
  wire [DW-1:0] wm_instr = merge(DW'(instr_reg), wdata, wstrb);
  wire [DW-1:0] wm_acc   = merge(DW'(acc_reg), wdata, wstrb);
  wire [DW-1:0] wm_link  = merge(DW'(link_reg), wdata, wstrb);
  wire [DW-1:0] wm_pc    = merge(DW'(pc_reg), wdata, wstrb);
  wire [DW-1:0] wm_sw    = merge(DW'(sw_reg), wdata, wstrb);

  // Register views
  always_comb begin
    ctrl_rd                = '0;
    ctrl_rd[`OME_C_RUN]    = run_reg;
    ctrl_rd[`OME_C_BANK]   = bank_reg;
    ctrl_rd[`OME_C_USER]   = user_reg;
    ctrl_rd[`OME_C_PROT]   = prot_reg;
    stat_rd                = '0;
    stat_rd[`OME_S_RUN]    = run_reg;
    stat_rd[`OME_S_BUSY]   = busy;
    stat_rd[`OME_S_INHIB]  = inhib_reg;
    stat_rd[`OME_S_UNSUP]  = unsup_reg;
  end

  // Word deposited by the subroutine jump
  always_comb begin
    deposit               = '0;
    deposit[`OME_D_LINK]  = link_reg;
    deposit[`OME_D_BANK]  = bank_reg;
    deposit[`OME_D_USER]  = user_reg;
    deposit[`OME_AW-1:0]  = pc_reg + `OME_PC_ONE;     // see RL14
  end

  // Execution sequence
  always_comb begin
    unique case (state_reg)
      ST_IDLE: state_next = start ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_next = is_call ? ST_CALL : ST_IDLE; // see RL2
      ST_CALL: state_next = ST_IDLE;                     // see RL14
      default: state_next = ST_IDLE;
    endcase
  end

  wire ome_addr_t pc_step = opr_res.skip ? `OME_PC_TWO
                                         : `OME_PC_ONE; // see RL17

  assign instr_next = start ? wm_instr[`OME_W-1:0] : instr_reg;
  assign acc_next   = opr_exec ? opr_res.acc :          // see RL4
                      we_acc   ? wm_acc[`OME_W-1:0] : acc_reg;
  assign link_next  = opr_exec ? opr_res.link :
                      we_link  ? wm_link[0] : link_reg;
  assign pc_next    = opr_exec ? pc_reg + pc_step :
                      jump_now ? y_addr :               // see RL21
                      in_call  ? y_addr + `OME_PC_ONE : // see RL15
                      we_pc    ? wm_pc[`OME_AW-1:0] : pc_reg;
  assign sw_next    = we_sw ? wm_sw[`OME_W-1:0] : sw_reg;
  assign run_next   = (opr_exec & opr_res.halt) ? 1'b0 :  // see RL9
                      we_ctrl ? wm_ctrl[`OME_C_RUN] : run_reg;
  assign bank_next  = we_ctrl ? wm_ctrl[`OME_C_BANK] : bank_reg;
  assign user_next  = we_ctrl ? wm_ctrl[`OME_C_USER] : user_reg;
  assign prot_next  = we_ctrl ? wm_ctrl[`OME_C_PROT] : prot_reg;
  assign unsup_next = in_exec ? ~(is_opr | is_ujump | is_call) : unsup_reg;
  assign inhib_next = in_call ? ~(user_reg & prot_reg) :   // see RL16
                      (in_exec & ~is_call) ? 1'b0 : inhib_reg;
  assign memwr_next = '{valid: in_call, addr: y_addr, data: deposit};

  // Bus handshakes and read mux
  wire rd_take = arready_reg & arvalid;
  wire [DW-1:0] rd_word =
      (araddr == ADDR_W'(`OME_A_CTRL))  ? ctrl_rd :
      (araddr == ADDR_W'(`OME_A_STAT))  ? stat_rd :
      (araddr == ADDR_W'(`OME_A_INSTR)) ? DW'(instr_reg) :
      (araddr == ADDR_W'(`OME_A_ACC))   ? DW'(acc_reg) :
      (araddr == ADDR_W'(`OME_A_LINK))  ? DW'(link_reg) :
      (araddr == ADDR_W'(`OME_A_PC))    ? DW'(pc_reg) :
      (araddr == ADDR_W'(`OME_A_SW))    ? DW'(sw_reg) : '0;
  wire rd_map =
      (araddr == ADDR_W'(`OME_A_CTRL)) | (araddr == ADDR_W'(`OME_A_STAT)) |
      (araddr == ADDR_W'(`OME_A_INSTR)) | (araddr == ADDR_W'(`OME_A_ACC)) |
      (araddr == ADDR_W'(`OME_A_LINK)) | (araddr == ADDR_W'(`OME_A_PC)) |
      (araddr == ADDR_W'(`OME_A_SW));

  assign awready_next = awvalid & wvalid & ~awready_reg & ~bvalid_reg;
  assign bvalid_next  = wr_take | (bvalid_reg & ~bready);
  assign bresp_next   = wr_take ? (wr_ok ? `OME_RESP_OK : `OME_RESP_ERR)
                                : bresp_reg;
  assign arready_next = arvalid & ~arready_reg & ~rvalid_reg;
  assign rvalid_next  = rd_take | (rvalid_reg & ~rready);
  assign rresp_next   = rd_take ? (rd_map ? `OME_RESP_OK : `OME_RESP_ERR)
                                : rresp_reg;
  assign rdata_next   = rd_take ? rd_word : rdata_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `OME_RESP_OK;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `OME_RESP_OK;
      rdata_reg   <= '0;
    end else begin
      awready_reg <= awready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      instr_reg <= '0;
      acc_reg   <= '0;
      link_reg  <= 1'b0;
      pc_reg    <= '0;
      sw_reg    <= '0;
      run_reg   <= 1'b0;
      bank_reg  <= 1'b0;
      user_reg  <= 1'b0;
      prot_reg  <= 1'b0;
      unsup_reg <= 1'b0;
      inhib_reg <= 1'b0;
      memwr_reg <= '0;
    end else begin
      state_reg <= state_next;
      instr_reg <= instr_next;
      acc_reg   <= acc_next;
      link_reg  <= link_next;
      pc_reg    <= pc_next;
      sw_reg    <= sw_next;
      run_reg   <= run_next;
      bank_reg  <= bank_next;
      user_reg  <= user_next;
      prot_reg  <= prot_next;
      unsup_reg <= unsup_next;
      inhib_reg <= inhib_next;
      memwr_reg <= memwr_next;
    end
  end

  assign awready     = awready_reg;
  assign wready      = awready_reg;
  assign bvalid      = bvalid_reg;
  assign bresp       = bresp_reg;
  assign arready     = arready_reg;
  assign rvalid      = rvalid_reg;
  assign rresp       = rresp_reg;
  assign rdata       = rdata_reg;
  assign mem_wr      = memwr_reg;
  assign int_inhibit = inhib_reg;
  assign running     = run_reg;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_opr_one_cycle;
    start ##1 (in_exec && is_opr) |=> (state_reg == ST_IDLE);
  endproperty
  a_opr_one_cycle: assert property (p_opr_one_cycle) // see RL2
    else $error("operate took more than one cycle");

  property p_skip_or;
    opr_exec && !instr_reg[`OME_B_INV] && instr_reg[`OME_B_ZRO] &&
      acc_reg == '0 |=> pc_reg == $past(pc_reg) + `OME_PC_TWO;
  endproperty
  a_skip_or: assert property (p_skip_or) // see RL5
    else $error("zero test did not skip");

  property p_skip_and;
    opr_exec && instr_reg[`OME_B_INV] && instr_reg[`OME_B_ZRO] &&
      instr_reg[`OME_B_LNK] && !instr_reg[`OME_B_NEG] |=>
      pc_reg == $past(pc_reg) +
        (($past(acc_reg) != '0 && !$past(link_reg)) ? `OME_PC_TWO
                                                    : `OME_PC_ONE);
  endproperty
  a_skip_and: assert property (p_skip_and) // see RL6
    else $error("inverted skip condition wrong");

  property p_halt;
    opr_exec && instr_reg[`OME_B_STOP] |=> !running ##1 !running;
  endproperty
  a_halt: assert property (p_halt) // see RL9
    else $error("halt did not stop the program");

  property p_swap;
    in_exec && instr_reg == `OME_W_SWAP |=>
      acc_reg == {$past(acc_reg[`OME_HALF-1:0]),
                  $past(acc_reg[`OME_W-1:`OME_HALF])};
  endproperty
  a_swap: assert property (p_swap) // see RL18
    else $error("halves not swapped");

  property p_inc;
    in_exec && instr_reg == `OME_W_INCA |=>
      acc_reg == $past(acc_reg) + `OME_ACC_ONE && link_reg == $past(link_reg);
  endproperty
  a_inc: assert property (p_inc) // see RL7
    else $error("increment wrong");

  property p_link_inv;
    in_exec && instr_reg == `OME_W_INVL |=>
      link_reg != $past(link_reg) && acc_reg == $past(acc_reg);
  endproperty
  a_link_inv: assert property (p_link_inv) // see RL20
    else $error("link not inverted");

  property p_combo;
    in_exec && instr_reg == `OME_W_CLCM |=> acc_reg == '1;
  endproperty
  a_combo: assert property (p_combo) // see RL4
    else $error("clear then complement order wrong");

  property p_ujump;
    jump_now |=> pc_reg == $past(y_addr) && acc_reg == $past(acc_reg) &&
                 state_reg == ST_IDLE;
  endproperty
  a_ujump: assert property (p_ujump) // see RL21
    else $error("jump target wrong");

  property p_call;
    in_exec && is_call |=> ##1 (mem_wr.valid && mem_wr.addr == $past(y_addr, 2)
      && pc_reg == $past(y_addr, 2) + `OME_PC_ONE
      && acc_reg == $past(acc_reg, 2));
  endproperty
  a_call: assert property (p_call) // see RL15
    else $error("subroutine jump sequence wrong");

  property p_inhibit;
    in_call && !(user_reg && prot_reg) |=> int_inhibit;
  endproperty
  a_inhibit: assert property (p_inhibit) // see RL16
    else $error("interrupt not held off after subroutine jump");

  c_skip: cover property (opr_exec && opr_res.skip);
  c_call: cover property (mem_wr.valid);
  c_swap: cover property (in_exec && instr_reg == `OME_W_SWAP);
  c_halt: cover property (opr_exec && opr_res.halt);
endmodule

//--- ome_regs.svh
// Register map, field positions and constants for the operate executor
// Operation
// RL1: Opcode 74 operate class tests and alters accumulator and link, or halts.
// RL2: Every operate instruction finishes in one machine cycle.
// RL3: Each operate field bit triggers its own microaction independently; the code decodes bits 13 and 14 together as swap or increment.
// RL4: Combined microactions in one word all execute in that cycle.
// RL5: Bit 8 clear: skip when any selected condition holds.
// RL6: Bit 8 set: skip only when all selected inverted conditions hold.
// RL7: Bits 13 and 14 with bit 7 swap halves, without bit 7 increment.
// RL8: Bit 7 selects the two-place rotate form.
// RL9: Order: skips, clears, switch OR, complements, rotates, halt last.
// RL10: Software never mixes levels within one column.
// RL11: Software never combines two rotate microactions.
// RL12: Software never combines link invert with accumulator increment.
// RL13: Software avoids logically conflicting microaction combinations.
// RL14: Subroutine jump takes two cycles, deposits counter, link, modes.
// RL15: Subroutine jump continues at address plus one, accumulator kept.
// RL16: Outside protected user mode, no interrupt right after subroutine jump.
// RL17: A taken skip advances the program counter one extra place.
// RL18: Swap exchanges accumulator halves at once.
// RL19: Operate bit positions as laid out below.
// RL20: Link invert replaces link with its inverse in the cycle.
// RL21: Unconditional jump loads counter from address field, one cycle.
`ifndef OME_REGS_SVH
`define OME_REGS_SVH
`define OME_W        18
`define OME_HALF     9
`define OME_AW       13
`define OME_AXI_AW   8
`define OME_OP_HI    17
`define OME_OP_LO    14
`define OME_OP_OPR   4'hF
`define OME_OP_UJUMP 4'hC
`define OME_OP_CALL  4'h2
// Operate bit n sits at vector index 17-n
`define OME_B_CLRA   12
`define OME_B_CLRL   11
`define OME_B_ROT2   10
`define OME_B_INV    9
`define OME_B_LNK    8
`define OME_B_ZRO    7
`define OME_B_NEG    6
`define OME_B_STOP   5
`define OME_B_RR     4
`define OME_B_RL     3
`define OME_B_ORSW   2
`define OME_B_INVL   1
`define OME_B_INVA   0
`define OME_SIGN     17
`define OME_D_LINK   17
`define OME_D_BANK   16
`define OME_D_USER   15
`define OME_A_CTRL   8'h00
`define OME_A_STAT   8'h04
`define OME_A_INSTR  8'h08
`define OME_A_ACC    8'h0C
`define OME_A_LINK   8'h10
`define OME_A_PC     8'h14
`define OME_A_SW     8'h18
`define OME_C_RUN    0
`define OME_C_BANK   1
`define OME_C_USER   2
`define OME_C_PROT   3
`define OME_S_RUN    0
`define OME_S_BUSY   1
`define OME_S_INHIB  2
`define OME_S_UNSUP  3
`define OME_RESP_OK  2'h0
`define OME_RESP_ERR 2'h2
`define OME_PC_ONE   13'h0001
`define OME_PC_TWO   13'h0002
`define OME_ACC_ONE  18'h00001
`define OME_W_INCA   18'h3C018
`define OME_W_SWAP   18'h3C418
`define OME_W_INVL   18'h3C002
`define OME_W_CLCM   18'h3D001
`endif

//--- ome_pkg.sv
// Types shared by the operate executor
package ome_pkg;
  `include "ome_regs.svh"
  typedef logic [`OME_W-1:0]  ome_word_t;
  typedef logic [`OME_AW-1:0] ome_addr_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CALL} ome_state_e;
  typedef struct packed {
    logic      valid;
    ome_addr_t addr;
    ome_word_t data;
  } ome_memwr_s;
  typedef struct packed {
    ome_word_t acc;
    logic      link;
    logic      skip;
    logic      halt;
  } ome_opr_s;
endpackage

//--- ome_opr_unit.sv
`timescale 1ns/1ps
// Combinational operate-class microaction datapath
`include "ome_regs.svh"
module ome_opr_unit (
  input  ome_pkg::ome_word_t word,
  input  ome_pkg::ome_word_t acc_in,
  input  logic               link_in,
  input  ome_pkg::ome_word_t switches,
  output ome_pkg::ome_opr_s  result
);
  import ome_pkg::*;

  // Skip tests look at the incoming values
  wire            ac_zero = (acc_in == '0);
  wire            ac_neg  = acc_in[`OME_SIGN];
  wire            or_hit  = (word[`OME_B_LNK] & link_in) |
                            (word[`OME_B_ZRO] & ac_zero) |
                            (word[`OME_B_NEG] & ac_neg);   // see RL5
  wire            and_hit = (~word[`OME_B_LNK] | ~link_in) &
                            (~word[`OME_B_ZRO] | ~ac_zero) &
                            (~word[`OME_B_NEG] | ~ac_neg); // see RL6

  // Clears, then switch OR and complements
  wire ome_word_t acc_clr = word[`OME_B_CLRA] ? '0 : acc_in;   // see RL19
  wire            lnk_clr = word[`OME_B_CLRL] ? 1'b0 : link_in;
  wire ome_word_t acc_or  = word[`OME_B_ORSW] ? (acc_clr | switches)
                                              : acc_clr;
  wire ome_word_t acc_cm  = word[`OME_B_INVA] ? ~acc_or : acc_or;
  wire            lnk_cm  = word[`OME_B_INVL] ? ~lnk_clr : lnk_clr; // see RL20

  // Rotate group through link and accumulator
  wire            rot_r   = word[`OME_B_RR];
  wire            rot_l   = word[`OME_B_RL];
  wire            two     = word[`OME_B_ROT2];
  wire            swap    = rot_r & rot_l & two;    // see RL7
  wire            inc     = rot_r & rot_l & ~two;
  wire [`OME_W:0] ring    = {lnk_cm, acc_cm};
  wire [`OME_W:0] ring_r1 = {ring[0], ring[`OME_W:1]};
  wire [`OME_W:0] ring_r2 = {ring_r1[0], ring_r1[`OME_W:1]};
  wire [`OME_W:0] ring_l1 = {ring[`OME_W-1:0], ring[`OME_W]};
  wire [`OME_W:0] ring_l2 = {ring_l1[`OME_W-1:0], ring_l1[`OME_W]};
  wire [`OME_W:0] ring_sw = {lnk_cm, acc_cm[`OME_HALF-1:0],
                             acc_cm[`OME_W-1:`OME_HALF]};  // see RL18
  wire [`OME_W:0] ring_in = {lnk_cm, acc_cm + `OME_ACC_ONE};
  wire [`OME_W:0] ring_o  = swap  ? ring_sw :
                            inc   ? ring_in :
                            rot_r ? (two ? ring_r2 : ring_r1) :
                            rot_l ? (two ? ring_l2 : ring_l1) :
                            ring;                    // see RL8

  assign result.acc  = ring_o[`OME_W-1:0];
  assign result.link = ring_o[`OME_W];
  assign result.skip = word[`OME_B_INV] ? and_hit : or_hit;
  assign result.halt = word[`OME_B_STOP];            // see RL9
endmodule

//--- ome_core_mem.sv
`timescale 1ns/1ps
// Core memory model that receives subroutine jump deposit writes
module ome_core_mem (
  input logic                aclk,
  input logic                aresetn,
  input ome_pkg::ome_memwr_s mem_wr
);
  import ome_pkg::*;
  ome_word_t core_mem [ome_addr_t];
  int        wr_count = 0;
  // Unwritten words read back as a pattern, never as a stale value
  function automatic ome_word_t peek(input ome_addr_t a);
    return core_mem.exists(a) ? core_mem[a] : 18'h2AAAA;
  endfunction
  always @(posedge aclk) begin
    if (aresetn === 1'h1 && mem_wr.valid === 1'h1) begin
      core_mem[mem_wr.addr] = mem_wr.data;
      wr_count++;
    end
  end
endmodule

//--- ome_exec_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the operate and jump executor
`include "ome_regs.svh"
module ome_exec_tb;
  import ome_pkg::*;
  typedef struct packed {
    ome_word_t instr;
    ome_word_t acc;
    logic      link;
    ome_word_t acc_x;
    logic      link_x;
    ome_addr_t pc_x;
  } ome_row_s;
  localparam int NROWS = 24;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, int_inhibit, running;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  ome_memwr_s  mem_wr;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;
  // Instruction, accumulator and link in, expected accumulator, link, counter
  ome_row_s    rows [NROWS] = '{
    '{18'h3C180, 18'h00000, 1'h0, 18'h00000, 1'h0, 13'h0102},
    '{18'h3C180, 18'h00005, 1'h1, 18'h00005, 1'h1, 13'h0102},
    '{18'h3C180, 18'h00005, 1'h0, 18'h00005, 1'h0, 13'h0101},
    '{18'h3C380, 18'h00005, 1'h0, 18'h00005, 1'h0, 13'h0102},
    '{18'h3C380, 18'h00005, 1'h1, 18'h00005, 1'h1, 13'h0101},
    '{18'h3C380, 18'h00000, 1'h0, 18'h00000, 1'h0, 13'h0101},
    '{18'h3C200, 18'h00000, 1'h0, 18'h00000, 1'h0, 13'h0102},
    '{18'h3C040, 18'h20000, 1'h0, 18'h20000, 1'h0, 13'h0102},
    '{18'h3C240, 18'h20000, 1'h0, 18'h20000, 1'h0, 13'h0101},
    '{18'h3D080, 18'h00005, 1'h1, 18'h00000, 1'h1, 13'h0101},
    '{18'h3D800, 18'h12345, 1'h1, 18'h00000, 1'h0, 13'h0101},
    '{18'h3D001, 18'h12345, 1'h0, 18'h3FFFF, 1'h0, 13'h0101},
    '{18'h3C002, 18'h00007, 1'h0, 18'h00007, 1'h1, 13'h0101},
    '{18'h3C004, 18'h00A00, 1'h0, 18'h00F00, 1'h0, 13'h0101},
    '{18'h3C010, 18'h00001, 1'h0, 18'h00000, 1'h1, 13'h0101},
    '{18'h3C008, 18'h20000, 1'h0, 18'h00000, 1'h1, 13'h0101},
    '{18'h3C410, 18'h00002, 1'h0, 18'h00000, 1'h1, 13'h0101},
    '{18'h3C408, 18'h10000, 1'h0, 18'h00000, 1'h1, 13'h0101},
    '{18'h3C418, 18'h001FF, 1'h1, 18'h3FE00, 1'h1, 13'h0101},
    '{18'h3C018, 18'h3FFFF, 1'h1, 18'h00000, 1'h1, 13'h0101},
    '{18'h3D018, 18'h00005, 1'h0, 18'h00001, 1'h0, 13'h0101},
    '{18'h30123, 18'h00005, 1'h1, 18'h00005, 1'h1, 13'h0123},
    '{18'h3C802, 18'h00000, 1'h0, 18'h00000, 1'h1, 13'h0101},
    '{18'h3C019, 18'h00005, 1'h0, 18'h3FFFB, 1'h0, 13'h0101}
  };

  ome_exec dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .mem_wr, .int_inhibit, .running);
  ome_core_mem mem (.aclk, .aresetn, .mem_wr);

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'h1);
        awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'h1);
        wvalid <= 1'h0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'h1);
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    v = rdata;
    r = rresp;
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, arvalid} = 4'h0;
    {awaddr, araddr, wdata} = 48'h0;
    {bready, rready} = 2'h3;
    wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`OME_A_PC);
    chk("pc after reset", v, 32'h0);
    wr(`OME_A_INSTR, 32'h0003C200);
    chk("instr while stopped", r, `OME_RESP_ERR);
    wr(`OME_A_SW, 32'h00000500);
    rd(`OME_A_SW);
    chk("switches", v, 32'h00000500);
    wr(`OME_A_CTRL, 32'h00000001);
    chk("running", running, 32'h1);
    for (int i = 0; i < NROWS; i++) begin
      wr(`OME_A_ACC, {14'h0, rows[i].acc});
      wr(`OME_A_LINK, {31'h0, rows[i].link});
      wr(`OME_A_PC, 32'h00000100);
      wr(`OME_A_INSTR, {14'h0, rows[i].instr});
      chk("instr resp", r, `OME_RESP_OK);
      rd(`OME_A_ACC);
      chk("acc", v, {14'h0, rows[i].acc_x});
      rd(`OME_A_LINK);
      chk("link", v, {31'h0, rows[i].link_x});
      rd(`OME_A_PC);
      chk("pc", v, {19'h0, rows[i].pc_x});
    end
    wr(`OME_A_ACC, 32'h00000005);
    wr(`OME_A_INSTR, 32'h0003D020);
    rd(`OME_A_ACC);
    chk("acc at halt", v, 32'h0);
    chk("running at halt", running, 32'h0);
    wr(`OME_A_INSTR, 32'h0003C001);
    chk("instr after halt", r, `OME_RESP_ERR);
    wr(8'h3C, 32'h00000001);
    chk("unmapped write", r, `OME_RESP_ERR);
    rd(8'h40);
    chk("unmapped read", {r, v[29:0]}, {`OME_RESP_ERR, 30'h0});
    wr(`OME_A_CTRL, 32'h00000003);
    wr(`OME_A_ACC, 32'h00001234);
    wr(`OME_A_LINK, 32'h00000001);
    wr(`OME_A_PC, 32'h00000200);
    wr(`OME_A_INSTR, 32'h00008456);
    rd(`OME_A_PC);
    chk("pc after call", v, 32'h00000457);
    rd(`OME_A_ACC);
    chk("acc after call", v, 32'h00001234);
    chk("deposit count", 32'(mem.wr_count), 32'h1);
    chk("deposit", {14'h0, mem.peek(13'h0456)}, 32'h00030201);
    chk("inhibit", int_inhibit, 32'h1);
    wr(`OME_A_INSTR, 32'h0003C000);
    rd(`OME_A_PC);
    chk("inhibit after next", int_inhibit, 32'h0);
    wr(`OME_A_INSTR, 32'h00000000);
    rd(`OME_A_STAT);
    chk("unsupported opcode", v, 32'h00000009);
    wr(`OME_A_CTRL, 32'h0000000F);
    rd(`OME_A_CTRL);
    chk("ctrl", v, 32'h0000000F);
    wr(`OME_A_INSTR, 32'h00008456);
    rd(`OME_A_PC);
    chk("user deposit", {14'h0, mem.peek(13'h0456)}, 32'h00038459);
    chk("user inhibit", int_inhibit, 32'h0);
    rd(`OME_A_STAT);
    chk("status", v, 32'h00000001);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`OME_A_ACC);
    chk("acc after reset", v, 32'h0);
    chk("running after reset", running, 32'h0);
    final_report();
  end
endmodule
